// ===== rtl/dcs_cycle_steal.sv
// Cycle-steal bus ownership and block sequencing for one DMA channel
// Summary of operation
// RULE_01: Each request moves one unit, except block last and chain-mode block first.
// RULE_02: Other bus requests are sampled and granted only while sampling signal high.
// RULE_03: Last unit of non-final block in repeat/chain modes, then 3 cycles, release.
// RULE_04: Software uses link chain 16-bit fixed side only on wide bus, even address.
// RULE_05: CPU-to-controller handover takes one cycle before transfer starts.
// RULE_06: Controller-to-CPU handover takes one cycle after activity ends.
// RULE_07: Two-bus-cycle unit is read then write, each stretched by wait cycles.
// RULE_08: Last unit of transfer or block followed immediately by 3 closing cycles.
// RULE_09: Chain-mode block first request: array state then first unit, bus kept.
// RULE_10: Array state lasts params times reads times 3 clocks, plus one cycle.
// RULE_11: Link chain fetches 4 or 3 parameters, read 2 or 4 times each.
// RULE_12: Array chain fetches 3 or 2 parameters, read 2 or 4 times each.
// RULE_13: After servicing one request the bus returns to the CPU.
// RULE_14: Array state reads 2-byte units, loads registers, holds acknowledge high.
// RULE_15: Software places parameters at even address; last link address is zero.
// RULE_16: Link chain ends when link latch and byte count are zero; raise interrupt.
// RULE_17: Bus is requested and granted before array state or unit transfer.
`timescale 1ns/1ps
module dcs_cycle_steal
	import dcs_pkg::*;
(
	input  wire logic        clock_in,
	input  wire logic        rst_in,
	input  wire dcs_cfg_t    cfg_in,
	input  wire logic        dma_request_in,
	input  wire logic        bus_grant_in,
	input  wire logic        other_request_in,
	input  wire logic        forced_terminate_input,
	input  wire dcs_rd_t     param_rd_in,
	input  wire logic        read_done_in,
	input  wire logic        write_done_in,
	output logic             bus_request_out,
	output logic             sample_enable_out,
	output logic             other_grant_out,
	output logic             channel_acknowledge_out,
	output logic             bus_read_out,
	output logic             bus_write_out,
	output logic             param_read_out,
	output logic [23:0]      source_address_out,
	output logic [23:0]      destination_address_out,
	output logic [23:0]      remaining_byte_count_out,
	output logic             block_end_out,
	output logic             done_irq_out,
	output logic             busy_out
);

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_WAIT_GRANT,
		ST_TAKE,
		ST_ARRAY,
		ST_READ,
		ST_WRITE,
		ST_CLOSE,
		ST_GIVE
	} dcs_state_t;

	dcs_state_t           state_reg;
	logic [1:0]           close_cnt_reg;
	logic                 block_start_reg;
	logic                 final_reg;
	logic [23:0]          source_address_reg;
	logic [23:0]          destination_address_reg;
	logic [23:0]          remaining_byte_count_reg;
	logic [23:0]          link_latch_reg;
	logic [15:0]          low_half_reg;
	logic                 array_start;
	logic                 array_busy;
	logic                 array_strobe;
	logic                 array_done;
	logic [DCS_CNT_W-1:0] array_index;
	logic                 chain_mode;
	logic                 last_unit;
	logic [23:0]          step;
	logic [23:0]          count_after;
	logic [1:0]           slot;
	logic [23:0]          word_value;
	logic [1:0]           param_sel;

	assign chain_mode = (cfg_in.mode == DCS_MODE_ARRAY) || (cfg_in.mode == DCS_MODE_LINK);
	assign step       = cfg_in.unit_16 ? 24'h000002 : 24'h000001;
	assign count_after = (remaining_byte_count_reg > step) ?
		remaining_byte_count_reg - step : DCS_COUNT_RESET;
	assign last_unit  = (count_after == DCS_ZERO_24);

	// ----------------------------------------
	// Array timer
	// ----------------------------------------
	// Started during handover so the array state is exactly its counted length
	assign array_start = (state_reg == ST_TAKE) && chain_mode && block_start_reg; // RULE_10

	dcs_array_timer u_array_timer (
		.clock_in        (clock_in),
		.rst_in          (rst_in),
		.start_in        (array_start),
		.cfg_in          (cfg_in),
		.busy_out        (array_busy),
		.read_strobe_out (array_strobe),
		.read_index_out  (array_index),
		.done_out        (array_done)
	);

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			state_reg     <= ST_IDLE;
			close_cnt_reg <= 2'h0;
		end else begin
			case (state_reg)
				ST_IDLE: begin
					if (dma_request_in && !done_irq_out) begin
						state_reg <= ST_WAIT_GRANT; // RULE_17
					end
				end
				ST_WAIT_GRANT: begin
					if (bus_grant_in) begin
						state_reg <= ST_TAKE; // RULE_17
					end
				end
				ST_TAKE: begin
					// One handover cycle before any activity
					if (chain_mode && block_start_reg) begin
						state_reg <= ST_ARRAY; // RULE_05 RULE_09
					end else begin
						state_reg <= ST_READ; // RULE_05
					end
				end
				ST_ARRAY: begin
					if (array_done) begin
						state_reg <= ST_READ; // RULE_09
					end
				end
				ST_READ: begin
					if (read_done_in) begin
						state_reg <= cfg_in.two_bus_cycle ? ST_WRITE : (last_unit ? ST_CLOSE : ST_GIVE); // RULE_07
						close_cnt_reg <= 2'h0;
					end
				end
				ST_WRITE: begin
					if (write_done_in) begin
						state_reg <= last_unit ? ST_CLOSE : ST_GIVE; // RULE_01 RULE_07 RULE_08
						close_cnt_reg <= 2'h0;
					end
				end
				ST_CLOSE: begin
					if (close_cnt_reg == 2'(DCS_CLOSE_CYC - 1)) begin
						state_reg <= ST_GIVE; // RULE_03 RULE_08
					end else begin
						close_cnt_reg <= close_cnt_reg + 2'h1;
					end
				end
				ST_GIVE: begin
					state_reg <= ST_IDLE; // RULE_06 RULE_13
				end
				default: begin
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------
	// Block bookkeeping
	// ----------------------------------------
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			block_start_reg <= 1'b1;
			final_reg       <= 1'b0;
		end else if (state_reg == ST_CLOSE && close_cnt_reg == 2'h0) begin
			block_start_reg <= 1'b1;
			// Link chain stops on zero next-link latch; array chain per-block repeat
			final_reg <= (cfg_in.mode == DCS_MODE_LINK) ? (link_latch_reg == DCS_ZERO_24) :
				(cfg_in.mode == DCS_MODE_SINGLE); // RULE_16
		end else if (state_reg == ST_READ) begin
			block_start_reg <= 1'b0;
		end else if (state_reg == ST_IDLE && dma_request_in && done_irq_out) begin
			final_reg <= final_reg;
		end
	end

	// Sticky completion event until forced stop or new reset
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			done_irq_out <= 1'b0;
		end else if (state_reg == ST_GIVE && final_reg && remaining_byte_count_reg == DCS_ZERO_24) begin
			done_irq_out <= 1'b1; // RULE_16
		end else if (!forced_terminate_input) begin
			done_irq_out <= 1'b0;
		end
	end

	// ----------------------------------------
	// Parameter loading, 2 bytes per read
	// ----------------------------------------
	// Narrow bus: third and fourth reads of a parameter are not stored
	assign slot = cfg_in.wide_bus ? array_index[0 +: 2] & 2'h1 : array_index[0 +: 2];

	always_comb begin
		param_sel  = cfg_in.wide_bus ? array_index[2:1] : array_index[3:2];
		word_value = {param_rd_in.data[7:0], low_half_reg};
		if (!cfg_in.two_bus_cycle && param_sel != 2'h0) begin
			param_sel = param_sel + 2'h1;
		end
	end

	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			low_half_reg             <= 16'h0000;
			source_address_reg       <= DCS_ZERO_24;
			destination_address_reg  <= DCS_ZERO_24;
			remaining_byte_count_reg <= DCS_COUNT_RESET;
			link_latch_reg           <= DCS_ZERO_24;
		end else if (array_strobe && param_rd_in.valid) begin
			if (slot == 2'h0) begin
				low_half_reg <= param_rd_in.data; // RULE_14
			end else if (slot == 2'h1) begin
				case (param_sel) // RULE_14
					2'h0: source_address_reg <= word_value;
					2'h1: destination_address_reg <= word_value;
					2'h2: remaining_byte_count_reg <= word_value;
					2'h3: link_latch_reg <= word_value;
					default: link_latch_reg <= word_value;
				endcase
			end
		end else if (state_reg == ST_READ && read_done_in) begin
			source_address_reg <= source_address_reg + step;
		end else if ((state_reg == ST_WRITE && write_done_in) ||
			(state_reg == ST_READ && read_done_in && !cfg_in.two_bus_cycle)) begin
			destination_address_reg  <= destination_address_reg + step;
			remaining_byte_count_reg <= count_after;
		end
		if (state_reg == ST_READ && read_done_in) begin
			remaining_byte_count_reg <= cfg_in.two_bus_cycle ? remaining_byte_count_reg : count_after;
		end
		if (state_reg == ST_WRITE && write_done_in) begin
			remaining_byte_count_reg <= count_after;
			destination_address_reg  <= destination_address_reg + step;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign bus_request_out         = (state_reg != ST_IDLE) && (state_reg != ST_GIVE);
	assign busy_out                = (state_reg != ST_IDLE);
	// Other masters wait while the controller holds the bus
	assign sample_enable_out       = (state_reg == ST_IDLE) || (state_reg == ST_GIVE); // RULE_02
	assign other_grant_out         = sample_enable_out && other_request_in; // RULE_02
	assign channel_acknowledge_out = (state_reg == ST_ARRAY) || (state_reg == ST_READ) ||
		(state_reg == ST_WRITE); // RULE_14
	assign bus_read_out            = (state_reg == ST_READ);
	assign bus_write_out           = (state_reg == ST_WRITE);
	assign param_read_out          = (state_reg == ST_ARRAY); // RULE_10
	assign block_end_out           = (state_reg == ST_CLOSE);
	assign source_address_out      = source_address_reg;
	assign destination_address_out = destination_address_reg;
	assign remaining_byte_count_out = remaining_byte_count_reg;

endmodule

// ===== pkg/dcs_pkg.sv
// Package for the cycle-steal DMA sequencer: modes, timing counts, carriers
package dcs_pkg;

	// ----------------------------------------
	// Transfer modes
	// ----------------------------------------
	typedef enum logic [1:0] {
		DCS_MODE_SINGLE,
		DCS_MODE_REPEAT,
		DCS_MODE_ARRAY,
		DCS_MODE_LINK
	} dcs_mode_t;

	// ----------------------------------------
	// Timing counts in phi cycles
	// ----------------------------------------
	localparam int unsigned DCS_HANDOVER_CYC    = 1;
	localparam int unsigned DCS_CLOSE_CYC       = 3;
	localparam int unsigned DCS_PARAM_BUS_CYC   = 3;
	localparam int unsigned DCS_ARRAY_EXTRA_CYC = 1;
	localparam int unsigned DCS_ARRAY_PARAMS_2B = 3;
	localparam int unsigned DCS_ARRAY_PARAMS_1B = 2;
	localparam int unsigned DCS_LINK_PARAMS_2B  = 4;
	localparam int unsigned DCS_LINK_PARAMS_1B  = 3;
	localparam int unsigned DCS_READS_WIDE      = 2;
	localparam int unsigned DCS_READS_NARROW    = 4;

	// ----------------------------------------
	// Parameter word layout (24 data bits + 8 dummy)
	// ----------------------------------------
	localparam int unsigned DCS_ADDR_W   = 24;
	localparam int unsigned DCS_HALF_W   = 16;
	localparam int unsigned DCS_CNT_W    = 6;
	localparam logic [23:0] DCS_ZERO_24  = 24'h000000;
	localparam logic [23:0] DCS_COUNT_RESET = 24'h000000;

	// Channel configuration
	typedef struct packed {
		dcs_mode_t mode;
		logic      two_bus_cycle;
		logic      wide_bus;
		logic      unit_16;
	} dcs_cfg_t;

	// One parameter bus read (2-byte unit)
	typedef struct packed {
		logic        valid;
		logic [15:0] data;
	} dcs_rd_t;

endpackage

// ===== rtl/dcs_array_timer.sv
// Array-state duration counter for parameter fetch
`timescale 1ns/1ps
module dcs_array_timer
	import dcs_pkg::*;
(
	input  wire logic                 clock_in,
	input  wire logic                 rst_in,
	input  wire logic                 start_in,
	input  wire dcs_cfg_t             cfg_in,
	output logic                      busy_out,
	output logic                      read_strobe_out,
	output logic [DCS_CNT_W-1:0]      read_index_out,
	output logic                      done_out
);

	logic [DCS_CNT_W-1:0] reads_total;
	logic [1:0]           phase_reg;
	logic [DCS_CNT_W-1:0] index_reg;
	logic                 extra_reg;
	logic [2:0]           params;
	logic [2:0]           reads;

	// ----------------------------------------
	// Parameter count and reads per parameter
	// ----------------------------------------
	always_comb begin
		if (cfg_in.mode == DCS_MODE_LINK) begin
			params = cfg_in.two_bus_cycle ? 3'(DCS_LINK_PARAMS_2B) : 3'(DCS_LINK_PARAMS_1B); // RULE_11
		end else begin
			params = cfg_in.two_bus_cycle ? 3'(DCS_ARRAY_PARAMS_2B) : 3'(DCS_ARRAY_PARAMS_1B); // RULE_12
		end
		reads = cfg_in.wide_bus ? 3'(DCS_READS_WIDE) : 3'(DCS_READS_NARROW); // RULE_11
		reads_total = DCS_CNT_W'(params) * DCS_CNT_W'(reads);
	end

	// ----------------------------------------
	// Bus cycles of 3 clocks each, then one extra
	// ----------------------------------------
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			busy_out  <= 1'b0;
			phase_reg <= 2'h0;
			index_reg <= '0;
			extra_reg <= 1'b0;
		end else if (start_in && !busy_out) begin
			busy_out  <= 1'b1;
			phase_reg <= 2'h0;
			index_reg <= '0;
			extra_reg <= 1'b0;
		end else if (busy_out) begin
			if (extra_reg) begin
				busy_out  <= 1'b0; // RULE_10
				extra_reg <= 1'b0;
			end else if (phase_reg == 2'(DCS_PARAM_BUS_CYC - 1)) begin
				phase_reg <= 2'h0;
				if (index_reg == reads_total - DCS_CNT_W'(1)) begin
					extra_reg <= 1'b1; // RULE_10
				end else begin
					index_reg <= index_reg + DCS_CNT_W'(1);
				end
			end else begin
				phase_reg <= phase_reg + 2'h1;
			end
		end
	end

	assign read_strobe_out = busy_out && !extra_reg && (phase_reg == 2'(DCS_PARAM_BUS_CYC - 1));
	assign read_index_out  = index_reg;
	assign done_out        = busy_out && extra_reg;

endmodule

// ===== verif/dcs_cycle_steal_chk.sv
// Port checker for the cycle-steal sequencer
`timescale 1ns/1ps
module dcs_cycle_steal_chk
	import dcs_pkg::*;
(
	input wire logic        clock_in,
	input wire logic        rst_in,
	input wire dcs_cfg_t    cfg_in,
	input wire logic        bus_grant_in,
	input wire logic        other_request_in,
	input wire logic        read_done_in,
	input wire logic        sample_enable_out,
	input wire logic        other_grant_out,
	input wire logic        channel_acknowledge_out,
	input wire logic        bus_read_out,
	input wire logic        bus_write_out,
	input wire logic        param_read_out,
	input wire logic [23:0] remaining_byte_count_out,
	input wire logic        block_end_out,
	input wire logic        done_irq_out,
	input wire logic        busy_out
);
	default clocking @(posedge clock_in); endclocking
	default disable iff (rst_in);
	logic [6:0] len_reg;
	logic [6:0] exp_len;
	// ------
	// Array length: params x reads x 3 + 1
	// ------
	always_comb begin
		exp_len = (cfg_in.mode == DCS_MODE_LINK) ? (cfg_in.two_bus_cycle ? 7'h04 : 7'h03)
			: (cfg_in.two_bus_cycle ? 7'h03 : 7'h02);
		exp_len = exp_len * (cfg_in.wide_bus ? 7'h02 : 7'h04) * 7'h03 + 7'h01;
	end
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in)
			len_reg <= 7'h00;
		else
			len_reg <= param_read_out ? len_reg + 7'h01 : 7'h00;
	end
	a_array_len: assert property ($fell(param_read_out) |-> len_reg == exp_len)
		else $error("array state length wrong");
	a_array_ack: assert property (param_read_out |-> channel_acknowledge_out)
		else $error("acknowledge low in array state");
	a_array_unit: assert property ($fell(param_read_out) |-> bus_read_out && channel_acknowledge_out)
		else $error("bus released after array state");
	a_handover_one: assert property ($rose(channel_acknowledge_out) |-> $past(bus_grant_in, 2) && $past(bus_grant_in))
		else $error("work began without handover");
	a_write_after_read: assert property ($rose(bus_write_out) |-> $past(bus_read_out) && $past(read_done_in))
		else $error("write not after finished read");
	a_read_held: assert property (bus_read_out && !read_done_in |=> bus_read_out)
		else $error("read cut short");
	a_close_three: assert property ($rose(block_end_out) |-> $past(bus_write_out || bus_read_out) ##0 block_end_out [*3] ##1 !block_end_out)
		else $error("closing not three cycles");
	a_give_after_close: assert property ($fell(block_end_out) |-> sample_enable_out && !channel_acknowledge_out ##1 !busy_out)
		else $error("bus not returned after close");
	a_give_after_unit: assert property ($fell(channel_acknowledge_out) && !block_end_out |-> sample_enable_out ##1 !busy_out)
		else $error("bus not returned after unit");
	a_other_gate: assert property (other_grant_out == (sample_enable_out && other_request_in) && !(other_grant_out && channel_acknowledge_out))
		else $error("other request grant wrong");
	a_irq_zero: assert property ($rose(done_irq_out) |-> remaining_byte_count_out == 24'h000000)
		else $error("end interrupt with bytes left");
	c_array: cover property ($fell(param_read_out));
	c_close: cover property ($rose(block_end_out));
	c_other: cover property (other_grant_out);
	c_unit: cover property ($fell(channel_acknowledge_out) && !block_end_out);
endmodule
bind dcs_cycle_steal dcs_cycle_steal_chk chk_u (.clock_in, .rst_in, .cfg_in, .bus_grant_in,
	.other_request_in, .read_done_in, .sample_enable_out, .other_grant_out,
	.channel_acknowledge_out, .bus_read_out, .bus_write_out, .param_read_out,
	.remaining_byte_count_out, .block_end_out, .done_irq_out, .busy_out);

// ===== verif/dcs_bus_partner.sv
// Bus partner model: grants the bus, ends read and write cycles, serves parameters
`timescale 1ns/1ps
module dcs_bus_partner
	import dcs_pkg::*;
(
	input  wire logic       clock_in,
	input  wire logic       rst_in,
	input  wire logic [3:0] wait_in,
	input  wire logic [15:0] fill_in,
	input  wire logic       req_in,
	input  wire logic       rd_in,
	input  wire logic       wr_in,
	input  wire logic       par_in,
	output dcs_rd_t         par_data_out,
	output logic            grant_out,
	output logic            rd_done_out,
	output logic            wr_done_out
);
	logic [3:0] cnt_reg;
	logic       tog_reg;
	// Grant one edge after the request, never before it
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in)
			grant_out <= 1'b0;
		else
			grant_out <= req_in;
	end
	// Wait states stretch each cycle; 0 answers one clock after the cycle starts
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			cnt_reg <= 4'h0;
			rd_done_out <= 1'b0;
			wr_done_out <= 1'b0;
			tog_reg <= 1'b0;
		end else begin
			cnt_reg <= (!(rd_in || wr_in) || rd_done_out || wr_done_out) ? 4'h0 : cnt_reg + 4'h1;
			rd_done_out <= rd_in && !rd_done_out && cnt_reg == wait_in;
			wr_done_out <= wr_in && !wr_done_out && cnt_reg == wait_in;
			tog_reg <= !tog_reg;
		end
	end
	// Every half is fill_in: even fill keeps addresses even, zero fill ends a link chain
	assign par_data_out = par_in ? {1'b1, fill_in} : {1'b0, {16{tog_reg}}};
endmodule

// ===== verif/tb_dcs_cycle_steal.sv
// Self-checking bench for the cycle-steal sequencer
`timescale 1ns/1ps
module tb_dcs_cycle_steal
	import dcs_pkg::*;
;
	logic        clock_in = 1'b0;
	logic        rst_in = 1'b1;
	dcs_cfg_t    cfg_in = '0;
	logic        dma_request_in = 1'b0;
	logic        other_request_in = 1'b0;
	logic        forced_terminate_input = 1'b1;
	logic [3:0]  wait_in = 4'h0;
	dcs_rd_t     param_rd_in;
	logic        bus_grant_in, read_done_in, write_done_in, bus_request_out, sample_enable_out;
	logic        other_grant_out, channel_acknowledge_out, bus_read_out, bus_write_out;
	logic        param_read_out, block_end_out, done_irq_out, busy_out;
	logic [23:0] remaining_byte_count_out;
	logic [15:0] param_fill = 16'h0000;
	int          fails = 0;
	int          checks = 0;
	int          cyc = 0;
	int          np, ne, nr, nw, bad, fin;
	int          tab[8] = '{19, 13, 37, 25, 25, 19, 49, 37};
	dcs_cfg_t    c;
	always #4 clock_in = ~clock_in;
	dcs_cycle_steal dut_u (.clock_in, .rst_in, .cfg_in, .dma_request_in, .bus_grant_in,
		.other_request_in, .forced_terminate_input, .param_rd_in, .read_done_in,
		.write_done_in, .bus_request_out, .sample_enable_out, .other_grant_out,
		.channel_acknowledge_out, .bus_read_out, .bus_write_out, .param_read_out,
		.source_address_out(), .destination_address_out(), .remaining_byte_count_out,
		.block_end_out, .done_irq_out, .busy_out);
	dcs_bus_partner bus_u (.clock_in, .rst_in, .wait_in, .fill_in(param_fill),
		.req_in(bus_request_out),
		.rd_in(bus_read_out), .wr_in(bus_write_out), .par_in(param_read_out),
		.par_data_out(param_rd_in), .grant_out(bus_grant_in), .rd_done_out(read_done_in),
		.wr_done_out(write_done_in));
	// ------
	// Shared tasks
	// ------
	task automatic test_done();
		if (fails == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input logic ok, input string msg);
		checks++;
		if (ok !== 1'b1) begin
			fails++;
			$display("ERROR %0t %s", $time, msg);
		end
	endtask
	// Reset, then one request
	task automatic serve(input dcs_cfg_t cf, input logic [3:0] w);
		cfg_in = cf;
		wait_in = w;
		@(negedge clock_in);
		rst_in = 1'b1;
		repeat (2) @(negedge clock_in);
		rst_in = 1'b0;
		request();
	endtask
	// One request, observed until the bus comes back
	task automatic request();
		dma_request_in = 1'b1;
		{np, ne, nr, nw, bad, fin} = '0;
		@(negedge clock_in);
		dma_request_in = 1'b0;
		for (int n = 0; n < 300 && fin == 0; n++) begin
			np += param_read_out;
			ne += block_end_out;
			nr += bus_read_out;
			nw += bus_write_out;
			if ((param_read_out && !channel_acknowledge_out) || (bus_write_out && nr == 0)
				|| (other_grant_out && channel_acknowledge_out))
				bad++;
			fin = (n > 2 && busy_out === 1'b0);
			@(negedge clock_in);
		end
		chk(fin == 1, "bus never returned");
	endtask
	// ------
	// Scenarios
	// ------
	task automatic scn_table();
		for (int i = 0; i < 8; i++) begin
			c.mode = i[2] ? DCS_MODE_LINK : DCS_MODE_ARRAY;
			c.wide_bus = !i[1];
			c.unit_16 = !i[1];
			c.two_bus_cycle = !i[0];
			serve(c, {2'b00, i[0], 1'b0});
			chk(np == tab[i], "array state length");
			chk(bad == 0 && nr > 0, "no unit after array");
			chk(ne == 3, "closing cycles");
			if (i[2])
				chk(done_irq_out === 1'b1, "no end interrupt");
		end
	endtask
	// Done flag set: requests refused until a forced stop clears it
	task automatic scn_stop();
		dma_request_in = 1'b1;
		repeat (2) @(negedge clock_in);
		chk(busy_out === 1'b0 && done_irq_out === 1'b1, "request taken while done");
		dma_request_in = 1'b0;
		forced_terminate_input = 1'b0;
		@(negedge clock_in);
		chk(done_irq_out === 1'b0, "done flag not cleared");
		forced_terminate_input = 1'b1;
	endtask
	// Long block: first unit after array state, then a plain unit, then repeat mode
	task automatic scn_chain();
		param_fill = 16'h0010;
		c = '{mode: DCS_MODE_ARRAY, two_bus_cycle: 1'b1, wide_bus: 1'b1, unit_16: 1'b1};
		serve(c, 4'h0);
		chk(np == 19 && ne == 0 && nr == 2 && nw == 2, "block first unit wrong");
		chk(done_irq_out === 1'b0, "end interrupt mid block");
		request();
		chk(np == 0 && ne == 0 && nr == 2 && nw == 2, "middle unit wrong");
		chk(remaining_byte_count_out === 24'h10000C, "count not stepped");
		param_fill = 16'h0000;
		c.mode = DCS_MODE_REPEAT;
		serve(c, 4'h0);
		chk(ne == 3 && np == 0 && done_irq_out === 1'b0, "repeat block end wrong");
	endtask
	task automatic scn_single();
		c = '{mode: DCS_MODE_SINGLE, two_bus_cycle: 1'b1, wide_bus: 1'b1, unit_16: 1'b1};
		serve(c, 4'h3);
		chk(np == 0 && bad == 0, "single unit wrong");
		chk(nr >= 4 && nw >= 4, "wait states lost");
		chk(fin == 1, "bus not returned");
	endtask
	task automatic scn_other();
		other_request_in = 1'b1;
		@(negedge clock_in);
		chk(other_grant_out === 1'b1, "idle request refused");
		serve(c, 4'h0);
		chk(bad == 0 && fin == 1, "grant during transfer");
		other_request_in = 1'b0;
	endtask
	always @(posedge clock_in) begin
		cyc++;
		if (cyc == 4000) begin
			fails++;
			test_done();
		end
	end
	initial begin
		scn_table();
		scn_stop();
		scn_chain();
		scn_single();
		scn_other();
		test_done();
	end
endmodule
